// file: ecs_sequencer.sv
// eeprom configuration sequencer: upload and download engine
`timescale 1ns/1ps
module ecs_sequencer
  import ecs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic [4:0] power_up_pin_condition,
  input wire logic write_enable,
  input wire logic save_req,
  input wire logic load_req,
  input wire logic [4:0] user_condition,
  output ecs_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  output ecs_ee_req_t ee_req,
  input wire logic [7:0] ee_rdata,
  output logic io_update,
  output logic calibrate,
  output logic dist_sync,
  output logic busy,
  output logic fault,
  output logic complete
);

  ecs_state_t state;
  logic mode_up;
  logic [5:0] sp_ptr;
  logic [10:0] ee_ptr;
  logic [7:0] op;
  logic [7:0] remain;
  logic [15:0] tgt;
  logic [7:0] csum;
  logic [31:0] tags;
  logic [4:0] cond;
  logic skip;
  logic auto_pend;
  logic [7:0] fetched;
  logic run_ok;

  // download data source is the eeprom, upload opcode source is scratch pad
  assign fetched = mode_up ? reg_rdata : ee_rdata;
  // tag board empty or condition zero means run everything
  assign run_ok = (cond == 5'h00) || (tags == TAGS_RST) || tags[cond];

  ////////////////////////////////////////////////////////////////////
  // automatic download after reset; strap caught after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_pend <= 1'b1;
    end else if (soft_reset) begin
      auto_pend <= 1'b1;
    end else if (state == ST_IDLE) begin
      auto_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      mode_up <= 1'b0;
      sp_ptr <= 6'h00;
      ee_ptr <= EE_PTR_RST;
      op <= 8'h00;
      remain <= 8'h00;
      tgt <= 16'h0000;
      csum <= 8'h00;
      tags <= TAGS_RST;
      cond <= 5'h00;
      skip <= 1'b0;
      reg_req <= '0;
      ee_req <= '0;
      io_update <= 1'b0;
      calibrate <= 1'b0;
      dist_sync <= 1'b0;
      busy <= 1'b0;
      fault <= 1'b0;
      complete <= 1'b0;
    end else begin
      reg_req.rd <= 1'b0;
      reg_req.wr <= 1'b0;
      ee_req.rd <= 1'b0;
      ee_req.wr <= 1'b0;
      io_update <= 1'b0;
      calibrate <= 1'b0;
      dist_sync <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          busy <= 1'b0;
          // requests only taken here
          // a zero strap must not swallow a request in the rearm cycle
          if (auto_pend && !soft_reset &&
              power_up_pin_condition != 5'h00) begin
            mode_up <= 1'b0;
            cond <= power_up_pin_condition;
            tags <= TAGS_RST;
            fault <= 1'b0;
            complete <= 1'b0;
            busy <= 1'b1;
            state <= ST_FETCH;
          end else if (save_req && write_enable) begin
            mode_up <= 1'b1;
            busy <= 1'b1;
            state <= ST_FETCH;
          end else if (load_req) begin
            mode_up <= 1'b0;
            cond <= (user_condition != 5'h00) ? user_condition
                                              : power_up_pin_condition;
            tags <= TAGS_RST;
            fault <= 1'b0;
            complete <= 1'b0;
            busy <= 1'b1;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mode_up) begin
            // scratch pad read from its base upward
            reg_req.rd <= 1'b1;
            reg_req.buffered <= 1'b1;
            reg_req.addr <= SCRATCH_BASE + {10'h000, sp_ptr};
          end else begin
            ee_req.rd <= 1'b1;
            ee_req.addr <= ee_ptr;
          end
          state <= ST_OP;
        end
        ST_OP: begin
          op <= fetched;
          if (fetched <= DATA_MAX) begin
            remain <= fetched; // count is value plus one
            csum <= 8'h00;
            skip <= !mode_up && !run_ok;
            if (mode_up) begin
              ee_req.wr <= 1'b1;
              ee_req.addr <= ee_ptr;
              ee_req.wdata <= fetched;
              sp_ptr <= sp_ptr + 6'h01;
            end
            ee_ptr <= ee_ptr + 11'h001;
            state <= ST_ADDR_HI;
          end else if (fetched == OP_END) begin
            ee_ptr <= EE_PTR_RST;
            if (mode_up) begin
              // end is stored so that a download knows where to stop
              ee_req.wr <= 1'b1;
              ee_req.addr <= ee_ptr;
              ee_req.wdata <= fetched;
              sp_ptr <= 6'h00;
            end else if (!fault) begin
              complete <= 1'b1;
            end
            state <= ST_IDLE;
          end else if (mode_up && fetched == OP_PAUSE) begin
            sp_ptr <= 6'h00; // ee_ptr kept
            state <= ST_IDLE;
          end else if (mode_up) begin
            ee_req.wr <= 1'b1;
            ee_req.addr <= ee_ptr;
            ee_req.wdata <= fetched;
            ee_ptr <= ee_ptr + 11'h001;
            sp_ptr <= (sp_ptr == SCRATCH_LAST) ? 6'h00 : sp_ptr + 6'h01;
            state <= (sp_ptr == SCRATCH_LAST) ? ST_IDLE : ST_FETCH;
          end else begin
            ee_ptr <= ee_ptr + 11'h001;
            if (fetched >= OP_COND_NULL && fetched <= OP_COND_LAST) begin
              if (fetched == OP_COND_NULL) begin
                tags <= TAGS_RST;
              end else begin
                tags[{~fetched[4], fetched[3:0]}] <= 1'b1;
              end
            end else if (run_ok) begin
              io_update <= (fetched == OP_UPDATE);
              calibrate <= (fetched == OP_CAL);
              dist_sync <= (fetched == OP_SYNC);
            end
            state <= ST_FETCH;
          end
        end
        ST_ADDR_HI: begin
          if (mode_up) begin
            reg_req.rd <= 1'b1;
            reg_req.addr <= SCRATCH_BASE + {10'h000, sp_ptr};
          end else begin
            ee_req.rd <= 1'b1;
            ee_req.addr <= ee_ptr;
          end
          state <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          // lower-addressed byte carries the msb
          // remain[7] marks the second byte; counts never reach it
          if (!remain[7]) begin
            tgt[15:8] <= fetched;
            remain[7] <= 1'b1;
            if (mode_up) begin
              reg_req.rd <= 1'b1;
              reg_req.addr <= SCRATCH_BASE + {10'h000, sp_ptr + 6'h01};
            end else begin
              ee_req.rd <= 1'b1;
              ee_req.addr <= ee_ptr + 11'h001;
            end
          end else begin
            tgt[7:0] <= fetched;
            remain[7] <= 1'b0;
            state <= ST_MOVE;
          end
          if (mode_up) begin
            // address kept in the eeprom so a download can find the block
            ee_req.wr <= 1'b1;
            ee_req.addr <= ee_ptr;
            ee_req.wdata <= fetched;
            sp_ptr <= sp_ptr + 6'h01; // two steps of one
          end
          ee_ptr <= ee_ptr + 11'h001;
        end
        ST_MOVE: begin
          if (mode_up) begin
            reg_req.rd <= 1'b1;
            reg_req.buffered <= 1'b1;
            reg_req.addr <= tgt;
          end else begin
            ee_req.rd <= 1'b1;
            ee_req.addr <= ee_ptr;
          end
          state <= ST_MOVE_WAIT;
        end
        ST_MOVE_WAIT: begin
          csum <= csum + fetched;
          if (mode_up) begin
            ee_req.wr <= 1'b1;
            ee_req.addr <= ee_ptr;
            ee_req.wdata <= fetched;
          end else if (!skip) begin
            reg_req.wr <= 1'b1;
            reg_req.buffered <= 1'b1;
            reg_req.addr <= tgt;
            reg_req.wdata <= fetched;
          end
          ee_ptr <= ee_ptr + 11'h001; // one per byte
          tgt <= tgt + 16'h0001;
          remain <= remain - 8'h01;
          state <= (remain == 8'h00) ? ST_CSUM : ST_MOVE;
        end
        ST_CSUM: begin
          if (mode_up) begin
            ee_req.wr <= 1'b1; // checksum right after data
            ee_req.addr <= ee_ptr;
            ee_req.wdata <= csum;
            ee_ptr <= ee_ptr + 11'h001;
            state <= ST_FETCH;
          end else begin
            ee_req.rd <= 1'b1;
            ee_req.addr <= ee_ptr;
            state <= ST_CSUM_WAIT;
          end
        end
        ST_CSUM_WAIT: begin
          if (ee_rdata != csum) begin
            fault <= 1'b1;
          end
          ee_ptr <= ee_ptr + 11'h001;
          state <= ST_FETCH;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : ecs_sequencer

// file: ecs_pkg.sv
// package for the eeprom configuration sequencer
// Summary of operation
// - all instructions both modes; pause upload only
// - bytes 00..7F are data instructions
// - data byte count is value plus one
// - two address bytes follow data instruction
// - address msb in d7 of lower byte
// - data moves from target address upward
// - upload writes checksum after block data
// - download checksum mismatch sets fault flag
// - all checksums matching sets complete flag
// - B0..CF conditions; B0 null, B1..CF 1..31
// - pause keeps eeprom pointer for appending
// - write enable then save bit starts upload
// - upload reads scratch pad from 0E10 upward
// - non-data bytes copied, eeprom pointer advances
// - data: store opcode, take address, copy bytes
// - eeprom pointer skips count plus checksum
// - upload reads buffered copy of registers
// - conditions stored unchanged, no upload skipping
// - load bit starts download, self clears
// - download reads eeprom ascending until end
// - reset runs download on nonzero pin condition
// - end idles; resets pointers per mode
// - download 80 update, A0 calibrate, A1 sync
// - pause not stored, resets scratch pointer
// - conditional skipping by tag board in download
package ecs_pkg;
  localparam logic [15:0] SCRATCH_BASE = 16'h0E10;
  localparam logic [5:0] SCRATCH_LAST = 6'h2F;
  localparam logic [7:0] DATA_MAX = 8'h7F;
  localparam logic [7:0] OP_UPDATE = 8'h80;
  localparam logic [7:0] OP_CAL = 8'hA0;
  localparam logic [7:0] OP_SYNC = 8'hA1;
  localparam logic [7:0] OP_COND_NULL = 8'hB0;
  localparam logic [7:0] OP_COND_LAST = 8'hCF;
  localparam logic [7:0] OP_PAUSE = 8'hFE;
  localparam logic [7:0] OP_END = 8'hFF;
  localparam int EE_AW = 11;
  localparam logic [10:0] EE_PTR_RST = 11'h000;
  localparam logic [31:0] TAGS_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH = 4'b0001,
    ST_OP = 4'b0010,
    ST_ADDR_HI = 4'b0011,
    ST_ADDR_LO = 4'b0100,
    ST_MOVE = 4'b0101,
    ST_MOVE_WAIT = 4'b0110,
    ST_CSUM = 4'b0111,
    ST_CSUM_WAIT = 4'b1000
  } ecs_state_t;

  // register map port toward the device settings
  typedef struct packed {
    logic rd;
    logic wr;
    logic buffered;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ecs_reg_req_t;

  // eeprom array port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecs_ee_req_t;
endpackage : ecs_pkg

// file: ecs_mem_model.sv
// eeprom array and register map model facing the sequencer
`timescale 1ns/1ps
module ecs_mem_model
  import ecs_pkg::*;
(
  input wire logic sys_clk,
  input ecs_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input ecs_ee_req_t ee_req,
  output logic [7:0] ee_rdata
);
  logic [7:0] regs [0:65535];
  logic [7:0] ee [0:2047];
  // reads answer in the cycle the request stands; an idle port shows
  // the inverse so a sample taken at the wrong time never looks valid
  assign reg_rdata = reg_req.rd ? regs[reg_req.addr]
                                : ~regs[reg_req.addr];
  assign ee_rdata = ee_req.rd ? ee[ee_req.addr] : ~ee[ee_req.addr];
  always @(posedge sys_clk) begin
    if (reg_req.wr) regs[reg_req.addr] <= reg_req.wdata;
    if (ee_req.wr) ee[ee_req.addr] <= ee_req.wdata;
  end
endmodule : ecs_mem_model

// file: ecs_sequencer_asserts.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module ecs_sequencer_asserts
  import ecs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic save_req,
  input wire logic load_req,
  input wire logic write_enable,
  input ecs_reg_req_t reg_req,
  input ecs_ee_req_t ee_req,
  input wire logic io_update,
  input wire logic calibrate,
  input wire logic dist_sync,
  input wire logic busy,
  input wire logic fault,
  input wire logic complete
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_load;
    !busy && load_req;
  endsequence
  sequence s_save;
    !busy && save_req && write_enable;
  endsequence
  a_load_starts: assert property (s_load |=> busy)
    else $error("load request did not start a transfer");
  a_save_starts: assert property (s_save |=> busy)
    else $error("save request did not start a transfer");
  a_save_refused: assert property (!busy && save_req && !write_enable
    && !load_req |=> !busy)
    else $error("save without write enable started");
  a_read_follows: assert property ($rose(busy) |-> ##[0:2]
    (ee_req.rd || reg_req.rd))
    else $error("no read after transfer start");
  a_pulse_single: assert property ((io_update || calibrate || dist_sync)
    |=> !(io_update || calibrate || dist_sync))
    else $error("action pulse longer than one cycle");
  a_pulse_busy: assert property ((io_update || calibrate || dist_sync)
    |-> busy)
    else $error("action pulse outside a transfer");
  a_flag_excl: assert property (!(fault && complete))
    else $error("fault and complete both set");
  a_buffered_copy: assert property ((reg_req.rd || reg_req.wr)
    && reg_req.addr < SCRATCH_BASE |-> reg_req.buffered)
    else $error("register access not on buffered copy");
  a_ee_wr_busy: assert property (ee_req.wr |-> busy)
    else $error("eeprom write while idle");
endmodule : ecs_sequencer_asserts
bind ecs_sequencer ecs_sequencer_asserts u_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .save_req(save_req), .load_req(load_req),
  .write_enable(write_enable), .reg_req(reg_req), .ee_req(ee_req),
  .io_update(io_update), .calibrate(calibrate), .dist_sync(dist_sync),
  .busy(busy), .fault(fault), .complete(complete));

// file: test_eeprom_config_sequencer.sv
// self-checking bench for the configuration sequencer
`timescale 1ns/1ps
module test_eeprom_config_sequencer;
  import ecs_pkg::*;
  logic sys_clk, rst_n, soft_reset, write_enable, save_req, load_req;
  logic [4:0] power_up_pin_condition, user_condition;
  ecs_reg_req_t reg_req;
  ecs_ee_req_t ee_req;
  logic [7:0] reg_rdata, ee_rdata, d0, d1;
  logic io_update, calibrate, dist_sync, busy, fault, complete;
  logic [7:0] prog [0:7];
  logic [7:0] exp_ee [0:10];
  int miscompares, checked, n_cal, n_upd, n_sync, i;
  ecs_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .power_up_pin_condition(power_up_pin_condition),
    .write_enable(write_enable), .save_req(save_req), .load_req(load_req),
    .user_condition(user_condition), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ee_req(ee_req), .ee_rdata(ee_rdata),
    .io_update(io_update), .calibrate(calibrate), .dist_sync(dist_sync),
    .busy(busy), .fault(fault), .complete(complete));
  ecs_mem_model mem (.sys_clk(sys_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ee_req(ee_req), .ee_rdata(ee_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (calibrate === 1'b1) n_cal++;
  always @(posedge sys_clk) if (io_update === 1'b1) n_upd++;
  always @(posedge sys_clk) if (dist_sync === 1'b1) n_sync++;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] csum(input logic [7:0] a, b);
    return a + b;
  endfunction : csum
  task check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // bounded wait for idle; running out counts as a mismatch
  task wait_idle;
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge sys_clk);
    check({7'h00, busy}, 8'h00);
  endtask : wait_idle
  // one-cycle request, then a bounded wait for idle
  task start(input bit up);
    @(negedge sys_clk);
    if (up) save_req = 1'b1;
    else load_req = 1'b1;
    @(negedge sys_clk);
    save_req = 1'b0;
    load_req = 1'b0;
    wait_idle;
  endtask : start
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    {rst_n, soft_reset, write_enable, save_req, load_req} = 5'h00;
    power_up_pin_condition = 5'h00;
    user_condition = 5'h00;
    {miscompares, checked, n_cal, n_upd, n_sync} = 0;
    void'($urandom(32'hBDF1));
    // nonzero so a skipped block is told apart from a loaded one
    d0 = 8'($urandom) | 8'h01;
    d1 = 8'($urandom);
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    prog = '{8'hB1, 8'h01, 8'h01, 8'h00, 8'hA0, 8'h80, 8'hA1, 8'hFF};
    for (int k = 0; k < 8; k++) mem.regs[SCRATCH_BASE + k] = prog[k];
    mem.regs[16'h0100] = d0;
    mem.regs[16'h0101] = d1;
    mem.ee[0] = 8'h55;
    start(1'b1);
    check(mem.ee[0], 8'h55);
    $display("refused save done");
    write_enable = 1'b1;
    start(1'b1);
    exp_ee = '{8'hB1, 8'h01, 8'h01, 8'h00, d0, d1, csum(d0, d1), 8'hA0,
      8'h80, 8'hA1, 8'hFF};
    for (int k = 0; k < 11; k++) check(mem.ee[k], exp_ee[k]);
    check(8'(n_cal + n_upd + n_sync), 8'h00);
    $display("upload done");
    mem.regs[16'h0100] = 8'h00;
    mem.regs[16'h0101] = 8'h00;
    start(1'b0);
    check(mem.regs[16'h0100], d0);
    check(mem.regs[16'h0101], d1);
    check({6'h00, fault, complete}, 8'h01);
    check(8'(n_cal), 8'h01);
    check(8'(n_upd), 8'h01);
    check(8'(n_sync), 8'h01);
    $display("download done");
    mem.ee[6] = ~mem.ee[6];
    start(1'b0);
    check({6'h00, fault, complete}, 8'h02);
    $display("checksum fault done");
    mem.ee[6] = ~mem.ee[6];
    mem.regs[16'h0100] = 8'h00;
    user_condition = 5'h02;
    start(1'b0);
    check(mem.regs[16'h0100], 8'h00);
    check(8'(n_cal), 8'h02);
    $display("conditional skip done");
    user_condition = 5'h01;
    start(1'b0);
    check(mem.regs[16'h0100], d0);
    check(8'(n_cal), 8'h03);
    $display("conditional run done");
    user_condition = 5'h00;
    mem.regs[16'h0100] = 8'h00;
    power_up_pin_condition = 5'h01;
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
    @(negedge sys_clk);
    check({7'h00, busy}, 8'h01);
    wait_idle;
    check(mem.regs[16'h0100], d0);
    check(8'(n_sync), 8'h04);
    $display("automatic download done");
    test_done;
  end
endmodule : test_eeprom_config_sequencer
